// >>> dv/oau_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module oau_top_tb_top;
import oau_pkg::*;
logic clock, rst_n, avs_read, avs_write, avs_waitrequest, latch;
logic [17:0] avs_address;
logic [3:0] avs_byteenable;
logic [31:0] avs_writedata, avs_readdata, rd, lfsr;
oau_loop_status_t st;
logic [5:0] drv_unmute, mask;
logic [1:0] mode;
int fails, n_checks;
oau_top dut (.clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .digital_loop_ch_one(st), .drv_unmute(drv_unmute));
initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
end
function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction
function automatic logic cond_of(input logic [1:0] m, input oau_loop_status_t s);
    case (m)
        2'h0: return 1'b1;
        2'h1: return s.profile_active;
        2'h2: return s.phase_lock_detect & s.hitless_mode;
        default: return s.frequency_lock_detect & s.hitless_mode;
    endcase
endfunction
task automatic final_report;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
endtask
task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
        fails++;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
endtask
task automatic cmp_drv(input logic [5:0] got, input logic [5:0] exp);
    n_checks++;
    if (got !== exp) begin
        fails++;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
endtask
// Request held until waitrequest is seen low; one idle edge after, so no double drive
task automatic bus(input logic wr, input logic [17:0] a, input logic [3:0] be,
    input logic [31:0] d, output logic [31:0] q);
    int i;
    avs_address <= a;
    avs_byteenable <= be;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    i = 0;
    do begin
        @(posedge clock);
        i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    q = avs_readdata;
    if (avs_waitrequest !== 1'b0) begin
        fails++;
        final_report();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
endtask
task automatic chk;
    repeat (3) @(posedge clock);
    @(negedge clock);
    cmp_drv(drv_unmute, mask | {6{latch}});
    @(posedge clock);
    bus(1'b0, STAT_ADDR, 4'hF, '0, rd);
    cmp_word(rd, {24'h0, st.hitless_mode, cond_of(mode, st), mask | {6{latch}}});
endtask
task automatic wr_ctrl(input logic [5:0] m, input logic [1:0] md);
    bus(1'b1, CTRL_ADDR, 4'h1, {24'h0, m, md}, rd);
    mask = m;
    mode = md;
    latch = cond_of(md, st);
    chk();
endtask
task automatic set_st(input logic [3:0] s);
    @(posedge clock);
    st <= oau_loop_status_t'(s);
    latch = latch | cond_of(mode, oau_loop_status_t'(s));
    chk();
endtask
initial begin
    rst_n = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = '0;
    avs_byteenable = 4'h0; avs_writedata = '0; st = '0; lfsr = 32'd74231;
    fails = 0; n_checks = 0; mask = '0; mode = '0; latch = 1'b1;
    repeat (10) @(posedge clock);
    @(negedge clock);
    cmp_drv(drv_unmute, 6'h00);
    @(posedge clock);
    rst_n <= 1'b1;
    chk();
    bus(1'b0, CTRL_ADDR, 4'hF, '0, rd);
    cmp_word(rd, 32'h0000_0000);
    for (int md = 1; md < 4; md++) begin
        wr_ctrl(6'h00, md[1:0]);
        set_st(4'h3);
        set_st(4'h8);
        set_st(md == 1 ? 4'h4 : (md == 2 ? 4'hA : 4'h9));
        set_st(4'h0);
    end
    for (int i = 0; i < 6; i++) wr_ctrl(6'h01 << i, 2'h2);
    wr_ctrl(6'h2A, 2'h3);
    bus(1'b1, CTRL_ADDR, 4'h0, 32'h0000_00FF, rd);
    bus(1'b1, CTRL_ADDR + 18'h8, 4'hF, 32'h0000_00FF, rd);
    bus(1'b0, CTRL_ADDR, 4'hF, '0, rd);
    cmp_word(rd, 32'h0000_00AB);
    bus(1'b0, CTRL_ADDR + 18'h8, 4'hF, '0, rd);
    cmp_word(rd, 32'h0000_0000);
    wr_ctrl(6'h00, 2'h0);
    repeat (60) begin
        lfsr = lfsr_next(lfsr);
        if (lfsr[0]) wr_ctrl(lfsr[9:4], lfsr[3:2]);
        else set_st(lfsr[13:10]);
    end
    final_report();
end
endmodule
`default_nettype wire

// >>> logic/oau_pkg.sv
`default_nettype none
package oau_pkg;

    localparam int unsigned DATA_W = 32;
    localparam int unsigned NUM_DRV = 6;

    // Printed offsets are register indices; byte address is four times that
    localparam logic [15:0] CTRL_INDEX = 16'h14DC;
    localparam logic [15:0] STAT_INDEX = 16'h14DD;
    localparam logic [17:0] CTRL_ADDR = {CTRL_INDEX, 2'b00};
    localparam logic [17:0] STAT_ADDR = {STAT_INDEX, 2'b00};

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int unsigned MASK_LSB = 2;
    localparam int unsigned MASK_MSB = 7;
    localparam int unsigned MODE_LSB = 0;
    localparam int unsigned MODE_MSB = 1;
    localparam int unsigned STAT_COND_BIT = 6;
    localparam int unsigned STAT_HITLESS_BIT = 7;

    typedef enum logic [1:0] {
        OAU_MODE_OFF = 2'b00,
        OAU_MODE_PROFILE = 2'b01,
        OAU_MODE_PHASE = 2'b10,
        OAU_MODE_FREQ = 2'b11
    } oau_mode_t;

    typedef struct packed {
        logic [NUM_DRV-1:0] mask;
        oau_mode_t mode;
    } oau_ctrl_t;

    typedef struct packed {
        logic hitless_mode;
        logic profile_active;
        logic phase_lock_detect;
        logic frequency_lock_detect;
    } oau_loop_status_t;

endpackage

`default_nettype wire

// >>> logic/oau_top.sv
`timescale 1ns/1ns
`default_nettype none

module oau_top #(
    parameter int unsigned ADDR_W = 18
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [oau_pkg::DATA_W-1:0] avs_writedata,
    output logic [oau_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire oau_pkg::oau_loop_status_t digital_loop_ch_one,
    output logic [oau_pkg::NUM_DRV-1:0] drv_unmute
);
    import oau_pkg::*;

    initial begin
        if (ADDR_W < 18) begin
            $error("oau_top: ADDR_W must reach the control register byte address");
        end
        if (NUM_DRV != MASK_MSB - MASK_LSB + 1) begin
            $error("oau_top: NUM_DRV must match the mask field width");
        end
        if (STAT_COND_BIT < NUM_DRV || STAT_HITLESS_BIT < NUM_DRV) begin
            $error("oau_top: status flags overlap the driver bits");
        end
        if (DATA_W < 8) begin
            $error("oau_top: DATA_W must hold the 8-bit registers");
        end
    end

    // Driver order in drv_unmute, index 5 down to 0:
    // drv_ch_one_c_negative, drv_ch_one_c_positive, drv_ch_one_b_negative,
    // drv_ch_one_b_positive, drv_ch_one_a_negative, drv_ch_one_a_positive

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [17:0] target);
        addr_hit = (a == ADDR_W'(target));
    endfunction

    function automatic logic [7:0] ctrl_pack(input oau_ctrl_t c);
        ctrl_pack = {c.mask, c.mode};
    endfunction

    function automatic logic mode_condition(input oau_mode_t m, input oau_loop_status_t s);
        unique case (m)
            OAU_MODE_OFF: mode_condition = 1'b1;
            OAU_MODE_PROFILE: mode_condition = s.profile_active;
            OAU_MODE_PHASE: mode_condition = s.phase_lock_detect & s.hitless_mode;
            OAU_MODE_FREQ: mode_condition = s.frequency_lock_detect & s.hitless_mode;
        endcase
    endfunction

    // Bus slave: every access waits exactly one cycle
    logic ack_reg;
    logic ack_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic req;
    logic hit_ctrl;
    logic hit_stat;
    logic wr_ctrl;

    // Control and unmute state
    oau_ctrl_t ctrl_reg;
    oau_ctrl_t ctrl_next;
    logic [NUM_DRV-1:0] latch_reg;
    logic [NUM_DRV-1:0] latch_next;
    logic [NUM_DRV-1:0] unmute_reg;
    logic [NUM_DRV-1:0] unmute_next;
    logic cond;
    // Condition under the mode being written, used to re-arm the latch
    logic cond_new;

    assign req = avs_read | avs_write;
    assign hit_ctrl = addr_hit(avs_address, CTRL_ADDR);
    assign hit_stat = addr_hit(avs_address, STAT_ADDR);
    assign avs_waitrequest = req & ~ack_reg;
    assign avs_readdata = rdata_reg;
    assign wr_ctrl = avs_write & ack_reg & hit_ctrl & avs_byteenable[0];

    always_comb begin
        ack_next = req & ~ack_reg;
        rdata_next = rdata_reg;
        if (avs_read & ~ack_reg) begin
            // Unmapped addresses read as zero
            rdata_next = '0;
            if (hit_ctrl) begin
                rdata_next[7:0] = ctrl_pack(ctrl_reg);
            end else if (hit_stat) begin
                rdata_next[NUM_DRV-1:0] = unmute_reg;
                rdata_next[STAT_COND_BIT] = cond;
                rdata_next[STAT_HITLESS_BIT] = digital_loop_ch_one.hitless_mode;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    // Write takes effect at the edge where waitrequest is low
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next.mask = avs_writedata[MASK_MSB:MASK_LSB];
            ctrl_next.mode = oau_mode_t'(avs_writedata[MODE_MSB:MODE_LSB]);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= oau_ctrl_t'(CTRL_RESET);
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    assign cond = mode_condition(ctrl_reg.mode, digital_loop_ch_one);
    assign cond_new = mode_condition(ctrl_next.mode, digital_loop_ch_one);

    // Once the selected point is reached the drivers stay unmuted, so a
    // lock that later drops does not chop the clock; a control write re-arms
    // under the mode it stores, so the old mode's condition cannot leak through.
    always_comb begin
        if (wr_ctrl) begin
            latch_next = {NUM_DRV{cond_new}};
        end else begin
            latch_next = latch_reg | {NUM_DRV{cond}};
        end
        unmute_next = ctrl_reg.mask | latch_next;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            latch_reg <= '0;
            unmute_reg <= '0;
        end else begin
            latch_reg <= latch_next;
            unmute_reg <= unmute_next;
        end
    end

    assign drv_unmute = unmute_reg;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence seq_ctrl_write;
        avs_write && hit_ctrl && avs_byteenable[0] && avs_waitrequest;
    endsequence

    sequence seq_ctrl_done;
        avs_write && hit_ctrl && !avs_waitrequest;
    endsequence

    sequence seq_quiet;
        !wr_ctrl;
    endsequence

    // Handshake steps shared by the register checks
    sequence seq_read_done;
        avs_read && !avs_waitrequest;
    endsequence

    sequence seq_ctrl_read;
        avs_read && hit_ctrl && avs_waitrequest ##1 seq_read_done;
    endsequence

    sequence seq_stat_read;
        avs_read && hit_stat && avs_waitrequest ##1 seq_read_done;
    endsequence

    sequence seq_muted_idle;
        latch_reg == '0 && ctrl_reg.mask == '0 && !wr_ctrl;
    endsequence

    bus_one_wait_a: assert property (
        (req && avs_waitrequest) |=> !avs_waitrequest
    ) else $error("access not answered after one wait cycle");

    ctrl_store_a: assert property (
        seq_ctrl_write ##1 seq_ctrl_done |=>
            ctrl_pack(ctrl_reg) == $past(avs_writedata[7:0])
    ) else $error("control write not stored");

    mask_force_a: assert property (
        (ctrl_reg.mask != '0) |=> ((drv_unmute & $past(ctrl_reg.mask)) == $past(ctrl_reg.mask))
    ) else $error("masked driver not unmuted");

    mode_off_a: assert property (
        (ctrl_reg.mode == OAU_MODE_OFF) ##0 seq_quiet |=> (drv_unmute == {NUM_DRV{1'b1}})
    ) else $error("mode off did not unmute all drivers");

    profile_unmute_a: assert property (
        (ctrl_reg.mode == OAU_MODE_PROFILE && digital_loop_ch_one.profile_active)
            ##0 seq_quiet |=> (drv_unmute == {NUM_DRV{1'b1}})
    ) else $error("profile activation did not unmute");

    phase_unmute_a: assert property (
        (ctrl_reg.mode == OAU_MODE_PHASE && digital_loop_ch_one.phase_lock_detect
            && digital_loop_ch_one.hitless_mode) ##0 seq_quiet
            |=> (drv_unmute == {NUM_DRV{1'b1}})
    ) else $error("phase lock in hitless did not unmute");

    freq_unmute_a: assert property (
        (ctrl_reg.mode == OAU_MODE_FREQ && digital_loop_ch_one.frequency_lock_detect
            && digital_loop_ch_one.hitless_mode) ##0 seq_quiet
            |=> (drv_unmute == {NUM_DRV{1'b1}})
    ) else $error("frequency lock in hitless did not unmute");

    hold_muted_a: assert property (
        (ctrl_reg.mode inside {OAU_MODE_PHASE, OAU_MODE_FREQ}) && !digital_loop_ch_one.hitless_mode
            && latch_reg == '0 && ctrl_reg.mask == '0 ##0 seq_quiet
            |=> (drv_unmute == '0)
    ) else $error("driver unmuted without hitless condition");

    enable_combine_a: assert property (
        seq_quiet |=> (drv_unmute == ($past(ctrl_reg.mask) | $past(latch_reg)
            | {NUM_DRV{$past(cond)}}))
    ) else $error("unmute enable not mask or condition");

    rearm_latch_a: assert property (
        wr_ctrl |=> (latch_reg == {NUM_DRV{$past(cond_new)}})
    ) else $error("control write did not re-arm the unmute latch");

    latch_hold_a: assert property (
        (latch_reg != '0) ##0 seq_quiet |=> (latch_reg == {NUM_DRV{1'b1}})
    ) else $error("unmute latch dropped without a control write");

    mask_live_a: assert property (
        (latch_reg == '0 && !cond) ##0 seq_quiet
            |=> ((drv_unmute & ~$past(ctrl_reg.mask)) == '0)
    ) else $error("unmasked driver unmuted without condition");

    profile_wait_a: assert property (
        (ctrl_reg.mode == OAU_MODE_PROFILE && !digital_loop_ch_one.profile_active)
            ##0 seq_muted_idle |=> (drv_unmute == '0)
    ) else $error("driver unmuted before profile activation");

    phase_wait_a: assert property (
        (ctrl_reg.mode == OAU_MODE_PHASE && !digital_loop_ch_one.phase_lock_detect)
            ##0 seq_muted_idle |=> (drv_unmute == '0)
    ) else $error("driver unmuted before phase lock");

    freq_wait_a: assert property (
        (ctrl_reg.mode == OAU_MODE_FREQ && !digital_loop_ch_one.frequency_lock_detect)
            ##0 seq_muted_idle |=> (drv_unmute == '0)
    ) else $error("driver unmuted before frequency lock");

    hitless_gate_a: assert property (
        (ctrl_reg.mode inside {OAU_MODE_PHASE, OAU_MODE_FREQ})
            && !digital_loop_ch_one.hitless_mode |-> !cond
    ) else $error("lock condition met outside hitless mode");

    ctrl_read_a: assert property (
        seq_ctrl_read |-> (avs_readdata == {{(DATA_W-8){1'b0}}, ctrl_pack(ctrl_reg)})
    ) else $error("control read returned wrong value");

    stat_read_a: assert property (
        seq_stat_read |-> (avs_readdata[NUM_DRV-1:0] == $past(unmute_reg))
            && (avs_readdata[STAT_COND_BIT] == $past(cond))
            && (avs_readdata[STAT_HITLESS_BIT] == $past(digital_loop_ch_one.hitless_mode))
            && (avs_readdata[DATA_W-1:8] == '0)
    ) else $error("status read returned wrong value");

    unmapped_read_a: assert property (
        (avs_read && !hit_ctrl && !hit_stat && avs_waitrequest) ##1 seq_read_done
            |-> (avs_readdata == '0)
    ) else $error("unmapped read did not return zero");

    write_refuse_a: assert property (
        (avs_write && !avs_waitrequest && !(hit_ctrl && avs_byteenable[0]))
            |=> $stable(ctrl_reg)
    ) else $error("refused write changed the control register");

    ctrl_change_a: assert property (
        $changed(ctrl_reg) |-> $past(wr_ctrl)
    ) else $error("control register changed without a write");

    rdata_hold_a: assert property (
        !avs_read |=> $stable(avs_readdata)
    ) else $error("read data changed without a read");

    bus_back_a: assert property (
        (req && !avs_waitrequest) |=> !ack_reg
    ) else $error("acknowledge not cleared after completion");

endmodule

`default_nettype wire
